// *** lpm_controller.sv ***
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - slow mode divides system clock or runs from low-power clock, oscillators off.
// - peripheral clock gating mode gates bus clocks of unused peripherals.
// - wait-for-interrupt stops only the CPU clock; any interrupt restarts it.
// - stop disables clocks and peripherals, retains memory; osc/regulator off unless options keep them.
// - stop ends on wake-up line, or rtc event if rtc kept running.
// - stop can keep main oscillator, flash or main regulator enabled.
// - standby removes core supply; only rtc stays powered from backup.
// - standby ends on standby wake pin event or rtc alarm.
// - standby only allowed in single-supply scheme, not external core supply.
// - standby wake pin is input only, never output or alternate function.
// - rtc counters run except in stop without LPM_STOP_RTC_RUN set; alarm acts as low-power wake source.
// - after reset or stop/standby wake, cpu runs from rc oscillator while osc stabilizes.
// - five low power modes: slow, gating, wait, stop, standby.
module lpm_controller import lpm_pkg::*; #(
  parameter int NPERIPH = 16,
  parameter int NWAKE = 16,
  parameter int OSC_STAB_CYC = LPM_OSC_STAB_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [NWAKE-1:0] wake_lines,
  input wire logic irq_pending,
  input wire logic standby_wake_pin,
  input wire logic rtc_alarm,
  input wire logic rtc_periodic,
  input wire logic ext_core_supply,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic [NPERIPH-1:0] periph_clk_en,
  output logic main_osc_en,
  output logic pll_en,
  output logic flash_en,
  output logic main_vreg_en,
  output logic core_power_en,
  output logic use_rc_clk,
  output logic use_lp_clk,
  output logic rtc_clk_en
);
  typedef struct packed {
    lpm_state_t st;
    logic [2:0] mode;
    logic [4:0] stopcfg;
    logic [NPERIPH-1:0] peripheral_clock_gating_mode;
    logic [NWAKE-1:0] wake_en;
    logic [7:0] slowdiv;
    logic [31:0] stab_cnt;
    logic stby_refused;
    logic wake_seen;
    logic pin_q;
    logic [31:0] rdata;
    logic cpu_clk_en;
    logic sys_clk_en;
    logic [NPERIPH-1:0] periph_clk_en;
    logic main_osc_en;
    logic pll_en;
    logic flash_en;
    logic main_vreg_en;
    logic core_power_en;
    logic use_rc_clk;
    logic use_lp_clk;
    logic rtc_clk_en;
  } lpm_ctl_st_t;

  lpm_ctl_st_t s_reg, s_next;
  logic slow_tick;
  logic go;
  logic line_wake;
  logic pin_rise;
  logic rtc_wake;
  logic stby_wake;
  logic [NPERIPH-1:0] pcg_mask;

  lpm_divider #(.W(8)) u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .ce(ce),
    .div(s_reg.slowdiv),
    .tick(slow_tick)
  );

  assign go = wr && (addr == LPM_ADDR_GO);
  assign line_wake = |(wake_lines & s_reg.wake_en);
  // pin is input only; only its rising edge counts as a trigger
  assign pin_rise = standby_wake_pin && !s_reg.pin_q;

  // rtc only wakes stop when it was left running there
  assign rtc_wake = s_reg.stopcfg[LPM_STOP_RTC_RUN] &&
    (rtc_alarm || rtc_periodic);
  assign stby_wake = pin_rise || rtc_alarm;

  // per-peripheral gate, applied only while gating mode is entered;
  // taken from the programmed bits so the gate lands with the mode
  genvar g;
  generate
    for (g = 0; g < NPERIPH; g++) begin : g_pcg
      assign pcg_mask[g] = !s_reg.peripheral_clock_gating_mode[g];
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.pin_q = standby_wake_pin;
    s_next.rdata = 32'h0;
    // register writes
    if (wr) begin
      if (addr == LPM_ADDR_MODE) begin
        s_next.mode = wdata[2:0];
      end else if (addr == LPM_ADDR_STOPCFG) begin
        s_next.stopcfg = wdata[4:0];
      end else if (addr == LPM_ADDR_PCG) begin
        s_next.peripheral_clock_gating_mode = wdata[NPERIPH-1:0];
      end else if (addr == LPM_ADDR_WAKEEN) begin
        s_next.wake_en = wdata[NWAKE-1:0];
      end else if (addr == LPM_ADDR_SLOWDIV) begin
        s_next.slowdiv = wdata[7:0];
      end else if (addr == LPM_ADDR_STATUS) begin
        // write one clears sticky bits; a new event in this cycle wins below
        if (wdata[8]) begin
          s_next.stby_refused = 1'b0;
        end
        if (wdata[9]) begin
          s_next.wake_seen = 1'b0;
        end
      end
    end
    // register reads
    if (rd) begin
      if (addr == LPM_ADDR_MODE) begin
        s_next.rdata = {29'h0, s_reg.mode};
      end else if (addr == LPM_ADDR_STOPCFG) begin
        s_next.rdata = {27'h0, s_reg.stopcfg};
      end else if (addr == LPM_ADDR_PCG) begin
        s_next.rdata = 32'(s_reg.peripheral_clock_gating_mode);
      end else if (addr == LPM_ADDR_WAKEEN) begin
        s_next.rdata = 32'(s_reg.wake_en);
      end else if (addr == LPM_ADDR_STATUS) begin
        s_next.rdata = {22'h0, s_reg.wake_seen, s_reg.stby_refused,
                        5'h0, s_reg.st};
      end else if (addr == LPM_ADDR_SLOWDIV) begin
        s_next.rdata = {24'h0, s_reg.slowdiv};
      end else begin
        s_next.rdata = 32'h0;
      end
    end

    case (s_reg.st)
      LPM_RUN: begin
        // entry only on explicit go, one mode at a time
        if (go) begin
          case (s_reg.mode)
            LPM_REQ_SLOW: begin
              s_next.st = LPM_SLOW;
            end
            LPM_REQ_PCG: begin
              s_next.st = LPM_PCG;
            end
            LPM_REQ_WFI: begin
              s_next.st = LPM_WFI;
            end
            LPM_REQ_STOP: begin
              s_next.st = LPM_STOP;
            end
            LPM_REQ_STBY: begin
              if (ext_core_supply) begin
                s_next.stby_refused = 1'b1;
              end else begin
                s_next.st = LPM_STBY;
              end
            end
            default: begin
              s_next.st = LPM_RUN;
            end
          endcase
        end
      end
      LPM_SLOW: begin
        // software leaves slow by requesting go with mode none
        if (go && s_reg.mode == LPM_REQ_NONE) begin
          s_next.st = LPM_RUN;
        end
      end

      LPM_PCG: begin
        // same exit as slow; gate bits stay programmed for next entry
        if (go && s_reg.mode == LPM_REQ_NONE) begin
          s_next.st = LPM_RUN;
        end
      end
      LPM_WFI: begin
        if (irq_pending || line_wake) begin
          s_next.st = LPM_RUN;
          s_next.wake_seen = 1'b1;
        end
      end
      LPM_STOP: begin
        if (line_wake || rtc_wake) begin
          s_next.st = LPM_RESTART;
          s_next.stab_cnt = '0;
          s_next.wake_seen = 1'b1;
        end
      end
      LPM_STBY: begin
        if (stby_wake) begin
          s_next.st = LPM_RESTART;
          s_next.stab_cnt = '0;
          s_next.wake_seen = 1'b1;
        end
      end
      LPM_RESTART: begin
        // cpu already runs on rc clock; wait for main oscillator
        if (s_reg.stab_cnt >= 32'(OSC_STAB_CYC - 1)) begin
          s_next.st = LPM_RUN;
        end else begin
          s_next.stab_cnt = s_reg.stab_cnt + 32'h1;
        end
      end
      default: begin
        s_next.st = LPM_RUN;
      end
    endcase

    // outputs decoded from the next state so they come from flip-flops
    s_next.cpu_clk_en = 1'b1;
    s_next.sys_clk_en = 1'b1;
    s_next.periph_clk_en = '1;
    s_next.main_osc_en = 1'b1;
    s_next.pll_en = 1'b1;
    s_next.flash_en = 1'b1;
    s_next.main_vreg_en = 1'b1;
    s_next.core_power_en = 1'b1;
    s_next.use_rc_clk = 1'b0;
    s_next.use_lp_clk = 1'b0;
    s_next.rtc_clk_en = 1'b1;
    case (s_next.st)
      LPM_RUN: begin
        s_next.periph_clk_en = '1;
      end
      LPM_SLOW: begin
        if (s_reg.stopcfg[LPM_SLOW_USE_LP]) begin
          s_next.main_osc_en = 1'b0;
          s_next.pll_en = 1'b0;
          s_next.use_lp_clk = 1'b1;
        end else begin
          s_next.sys_clk_en = slow_tick;
          s_next.cpu_clk_en = slow_tick;
        end
      end
      LPM_PCG: begin
        s_next.periph_clk_en = pcg_mask;
      end
      LPM_WFI: begin
        s_next.cpu_clk_en = 1'b0;
      end
      LPM_STOP: begin
        s_next.cpu_clk_en = 1'b0;
        s_next.sys_clk_en = 1'b0;
        s_next.periph_clk_en = '0;
        s_next.pll_en = 1'b0;
        s_next.main_osc_en = s_reg.stopcfg[LPM_STOP_KEEP_OSC];
        s_next.flash_en = s_reg.stopcfg[LPM_STOP_KEEP_FLASH];
        s_next.main_vreg_en = s_reg.stopcfg[LPM_STOP_KEEP_VREG];
        s_next.rtc_clk_en = s_reg.stopcfg[LPM_STOP_RTC_RUN];
      end
      LPM_STBY: begin
        s_next.cpu_clk_en = 1'b0;
        s_next.sys_clk_en = 1'b0;
        s_next.periph_clk_en = '0;
        s_next.pll_en = 1'b0;
        s_next.main_osc_en = 1'b0;
        s_next.flash_en = 1'b0;
        s_next.main_vreg_en = 1'b0;
        s_next.core_power_en = 1'b0;
      end
      LPM_RESTART: begin
        s_next.use_rc_clk = 1'b1;
        s_next.pll_en = 1'b0;
        s_next.periph_clk_en = '1;
      end
      default: begin
        s_next.periph_clk_en = '1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // reset also starts from the rc clock with an oscillator wait
      s_reg.mode <= LPM_REQ_NONE;
      s_reg.peripheral_clock_gating_mode <= '0;
      s_reg.stab_cnt <= '0;
      s_reg.stby_refused <= 1'b0;
      s_reg.wake_seen <= 1'b0;
      // pin idles low, so no false edge follows reset
      s_reg.pin_q <= 1'b0;
      s_reg.rdata <= 32'h0;
      s_reg.pll_en <= 1'b0;
      s_reg.use_lp_clk <= 1'b0;
      s_reg.st <= LPM_RESTART;
      s_reg.stopcfg <= LPM_STOPCFG_RST;
      s_reg.slowdiv <= LPM_SLOWDIV_RST;
      s_reg.wake_en <= '1;
      s_reg.cpu_clk_en <= 1'b1;
      s_reg.sys_clk_en <= 1'b1;
      s_reg.periph_clk_en <= '1;
      s_reg.main_osc_en <= 1'b1;
      s_reg.flash_en <= 1'b1;
      s_reg.main_vreg_en <= 1'b1;
      s_reg.core_power_en <= 1'b1;
      s_reg.use_rc_clk <= 1'b1;
      s_reg.rtc_clk_en <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign cpu_clk_en = s_reg.cpu_clk_en;
  assign sys_clk_en = s_reg.sys_clk_en;
  assign periph_clk_en = s_reg.periph_clk_en;
  assign main_osc_en = s_reg.main_osc_en;
  assign pll_en = s_reg.pll_en;
  assign flash_en = s_reg.flash_en;
  assign main_vreg_en = s_reg.main_vreg_en;
  assign core_power_en = s_reg.core_power_en;
  assign use_rc_clk = s_reg.use_rc_clk;
  assign use_lp_clk = s_reg.use_lp_clk;
  assign rtc_clk_en = s_reg.rtc_clk_en;
endmodule

// *** lpm_pkg.sv ***
package lpm_pkg;
  localparam logic [3:0] LPM_ADDR_MODE = 4'h0;
  localparam logic [3:0] LPM_ADDR_STOPCFG = 4'h1;
  localparam logic [3:0] LPM_ADDR_PCG = 4'h2;
  localparam logic [3:0] LPM_ADDR_WAKEEN = 4'h3;
  localparam logic [3:0] LPM_ADDR_STATUS = 4'h4;
  localparam logic [3:0] LPM_ADDR_SLOWDIV = 4'h5;
  localparam logic [3:0] LPM_ADDR_GO = 4'h6;
  localparam logic [2:0] LPM_REQ_NONE = 3'h0;
  localparam logic [2:0] LPM_REQ_SLOW = 3'h1;
  localparam logic [2:0] LPM_REQ_PCG = 3'h2;
  localparam logic [2:0] LPM_REQ_WFI = 3'h3;
  localparam logic [2:0] LPM_REQ_STOP = 3'h4;
  localparam logic [2:0] LPM_REQ_STBY = 3'h5;
  // stop configuration field positions
  localparam int LPM_STOP_KEEP_OSC = 0;
  localparam int LPM_STOP_KEEP_FLASH = 1;
  localparam int LPM_STOP_KEEP_VREG = 2;
  localparam int LPM_STOP_RTC_RUN = 3;
  localparam int LPM_SLOW_USE_LP = 4;
  localparam logic [7:0] LPM_SLOWDIV_RST = 8'h07;
  localparam logic [4:0] LPM_STOPCFG_RST = 5'h00;
  localparam int LPM_SYS_CLK_HZ = 50000000;
  localparam int LPM_OSC_STAB_US = 100;
  localparam int LPM_OSC_STAB_CYC = LPM_OSC_STAB_US * (LPM_SYS_CLK_HZ / 1000000);
  typedef enum logic [2:0] {
    LPM_RUN, LPM_SLOW, LPM_PCG, LPM_WFI, LPM_STOP, LPM_STBY, LPM_RESTART
  } lpm_state_t;
endpackage

// *** lpm_divider.sv ***
`timescale 1ns/1ps
module lpm_divider import lpm_pkg::*; #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [W-1:0] div,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } lpm_div_st_t;
  lpm_div_st_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= div) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign tick = s_reg.tick;
endmodule

// *** lpm_monitor.sv ***
`timescale 1ns/1ps
module lpm_monitor #(
  parameter int NPERIPH = 16,
  parameter int NWAKE = 16,
  parameter int OSC_STAB_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic irq_pending,
  input wire logic standby_wake_pin,
  input wire logic rtc_alarm,
  input wire logic ext_core_supply,
  input wire logic cpu_clk_en,
  input wire logic sys_clk_en,
  input wire logic [NPERIPH-1:0] periph_clk_en,
  input wire logic main_osc_en,
  input wire logic pll_en,
  input wire logic flash_en,
  input wire logic core_power_en,
  input wire logic use_rc_clk,
  input wire logic rtc_clk_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  rst_state_a: assert property (disable iff (1'b0)
    srst && ce |=> use_rc_clk && !pll_en && cpu_clk_en)
    else $error("reset state wrong");
  rc_start_a: assert property (use_rc_clk |->
    main_osc_en && cpu_clk_en && !pll_en) else $error("rc start wrong");
  // bounds assume the shortened stabilisation count of 8
  osc_stab_a: assert property ($fell(srst) |->
    use_rc_clk ##[6:12] !use_rc_clk) else $error("stabilise time wrong");
  stby_power_a: assert property (!core_power_en |->
    !ext_core_supply && rtc_clk_en && !cpu_clk_en && !flash_en)
    else $error("standby power wrong");
  wfi_only_a: assert property (!cpu_clk_en && sys_clk_en |->
    &periph_clk_en && core_power_en) else $error("wait mode stops more");
  wfi_wake_a: assert property (!cpu_clk_en && sys_clk_en &&
    irq_pending |-> ##[1:3] cpu_clk_en) else $error("irq wake missed");
  pin_wake_a: assert property (!core_power_en &&
    $rose(standby_wake_pin) |-> ##[1:4] core_power_en)
    else $error("pin wake missed");
  alarm_wake_a: assert property (!core_power_en && rtc_alarm
    |-> ##[1:4] core_power_en) else $error("alarm wake missed");
  wake_rc_a: assert property ($rose(core_power_en) |->
    ##[0:1] use_rc_clk) else $error("wake skips rc start");
endmodule
bind lpm_controller lpm_monitor #(.NPERIPH(NPERIPH), .NWAKE(NWAKE),
  .OSC_STAB_CYC(OSC_STAB_CYC)) mon (.*);

// *** lpm_wake_model.sv ***
`timescale 1ns/1ps
module lpm_wake_model #(
  parameter int NWAKE = 16
) (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [2:0] sel,
  input wire logic [7:0] dly,
  input wire logic [3:0] line,
  output logic [NWAKE-1:0] wake_lines,
  output logic irq_pending,
  output logic standby_wake_pin,
  output logic rtc_alarm,
  output logic rtc_periodic
);
  logic [7:0] cnt_reg = 8'h00;
  logic [2:0] sel_reg = 3'h0;
  logic [3:0] line_reg = 4'h0;
  logic [1:0] hold_reg = 2'h0;
  logic on;
  always_ff @(posedge sys_clk) begin
    if (fire) begin
      cnt_reg <= dly + 8'h01;
      sel_reg <= sel;
      line_reg <= line;
    end else if (cnt_reg == 8'h01) begin
      cnt_reg <= 8'h00;
      hold_reg <= 2'h2;
    end else begin
      if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
      if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
    end
  end
  // events last two cycles so a level sampled once is never missed
  always_comb begin
    on = hold_reg != 2'h0;
    wake_lines = '0;
    if (on && sel_reg == 3'h1) wake_lines[line_reg] = 1'b1;
    irq_pending = on && sel_reg == 3'h0;
    standby_wake_pin = on && sel_reg == 3'h2;
    rtc_alarm = on && sel_reg == 3'h3;
    rtc_periodic = on && sel_reg == 3'h4;
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top import lpm_pkg::*;;
  logic sys_clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
  logic ce = 1'b1;
  logic ext = 1'b0, irq, pin, alm, per, cpu, sysc, osc, pll, fl, vr;
  logic core, rc, lp, rtc;
  logic [3:0] addr = 4'h0, line = 4'h0, c;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [2:0] sel = 3'h0;
  logic [7:0] dly = 8'h00;
  logic [15:0] wl, pe, m16;
  int fail_count = 0, checked = 0, seed = 3, i, n;
  initial forever #10 sys_clk = ~sys_clk;
  lpm_controller #(.OSC_STAB_CYC(8)) DUT (.sys_clk(sys_clk),
    .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wake_lines(wl), .irq_pending(irq),
    .standby_wake_pin(pin), .rtc_alarm(alm), .rtc_periodic(per),
    .ext_core_supply(ext), .cpu_clk_en(cpu), .sys_clk_en(sysc),
    .periph_clk_en(pe), .main_osc_en(osc), .pll_en(pll), .flash_en(fl),
    .main_vreg_en(vr), .core_power_en(core), .use_rc_clk(rc),
    .use_lp_clk(lp), .rtc_clk_en(rtc));
  lpm_wake_model far (.sys_clk(sys_clk), .fire(fire), .sel(sel),
    .dly(dly), .line(line), .wake_lines(wl), .irq_pending(irq),
    .standby_wake_pin(pin), .rtc_alarm(alm), .rtc_periodic(per));
  task automatic summarize;
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [5:0] exp_stop(input logic [3:0] cfg);
    return {3'b001, cfg[LPM_STOP_KEEP_OSC], cfg[LPM_STOP_KEEP_FLASH],
      cfg[LPM_STOP_KEEP_VREG]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask
  task automatic go(input logic [2:0] m);
    wr_reg(LPM_ADDR_MODE, {29'h0, m});
    wr_reg(LPM_ADDR_GO, 32'h1);
    cyc(2);
  endtask
  task automatic wake(input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    fire <= 1'b1;
    sel <= s;
    dly <= d;
    line <= 4'($random(seed));
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask
  task automatic wait_run;
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (!(cpu === 1'b1 && sysc === 1'b1 && rc === 1'b0 &&
      lp === 1'b0) && k < 400);
    if (k >= 400) begin
      fail_count++;
      summarize;
    end
    rd_reg(LPM_ADDR_STATUS);
    chk(v & 32'h7, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    wait_run;
    rd_reg(LPM_ADDR_SLOWDIV);
    chk(v, {24'h0, LPM_SLOWDIV_RST});
    rd_reg(LPM_ADDR_WAKEEN);
    chk(v & 32'hffff, 32'hffff);
    rd_reg(4'hf);
    chk(v, 32'h0);
    @(posedge sys_clk) ce <= 1'b0;
    wr_reg(LPM_ADDR_SLOWDIV, 32'h5);
    ce <= 1'b1;
    rd_reg(LPM_ADDR_SLOWDIV);
    chk(v, {24'h0, LPM_SLOWDIV_RST});
    wr_reg(LPM_ADDR_SLOWDIV, 32'h3);
    for (i = 0; i < 2; i++) begin
      wr_reg(LPM_ADDR_STOPCFG, (1 - i) << LPM_SLOW_USE_LP);
      go(LPM_REQ_SLOW);
      if (i == 0) chk({lp, osc, pll}, 3'b100);
      n = 0;
      repeat (32) begin
        @(negedge sys_clk);
        n += int'(cpu);
      end
      if (i == 1) chk(n, 8);
      go(LPM_REQ_NONE);
      wait_run;
    end
    m16 = 16'($random(seed));
    wr_reg(LPM_ADDR_PCG, {16'h0, m16});
    go(LPM_REQ_PCG);
    chk({cpu, pe}, {1'b1, ~m16});
    go(LPM_REQ_NONE);
    wait_run;
    for (i = 0; i < 2; i++) begin
      go(LPM_REQ_WFI);
      chk({cpu, sysc}, 2'b01);
      wake(3'(i), 8'($random(seed) & 31));
      wait_run;
    end
    for (i = 0; i < 2; i++) begin
      c = {i[0], 3'($random(seed))};
      wr_reg(LPM_ADDR_STOPCFG, {28'h0, c});
      go(LPM_REQ_STOP);
      chk({sysc, cpu, core, osc, fl, vr}, exp_stop(c));
      chk(rtc, c[LPM_STOP_RTC_RUN]);
      wake(3'h4, 8'h2);
      cyc(8);
      if (i == 0) chk(cpu, 1'b0);
      if (i == 0) wake(3'h1, 8'h3);
      wait_run;
    end
    @(posedge sys_clk) ext <= 1'b1;
    go(LPM_REQ_STBY);
    rd_reg(LPM_ADDR_STATUS);
    chk(v & 32'h107, 32'h100);
    wr_reg(LPM_ADDR_STATUS, 32'h100);
    ext <= 1'b0;
    for (i = 0; i < 2; i++) begin
      go(LPM_REQ_STBY);
      chk({core, rtc, cpu}, 3'b010);
      wake(i == 0 ? 3'h2 : 3'h3, 8'h4);
      wait_run;
    end
    summarize;
  end
endmodule
